/* core/swr_pkg.sv */
/*
 * swr_pkg: constants and types for the supervisory reset generator.
 * assumes a single 250 MHz core clock; all times except MR_MIN_PULSE_NS are converted to cycles here.
 */
package swr_pkg;

    localparam int unsigned CLK_PERIOD_PS       = 4000;

    // manual reset input timing
    localparam int unsigned MR_GLITCH_NS        = 100;
    localparam int unsigned MR_MIN_PULSE_NS     = 1000;
    localparam int unsigned MR_GLITCH_CYC       = (MR_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1)
                                                  / CLK_PERIOD_PS;

    // kick input timing
    localparam int unsigned KICK_PULSE_NS       = 50;
    localparam int unsigned KICK_PULSE_CYC      = (KICK_PULSE_NS * 1000) / CLK_PERIOD_PS;

    // reset timeout, 140 ms minimum
    localparam int unsigned RST_TIMEOUT_MS      = 140;
    localparam longint unsigned RST_TIMEOUT_CYC = (64'(RST_TIMEOUT_MS) * 64'd1000000000
                                                   + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // watchdog period, 1.60 s nominal, in ms
    localparam int unsigned WD_PERIOD_MS        = 1600;
    localparam longint unsigned WD_PERIOD_CYC   = (64'(WD_PERIOD_MS) * 64'd1000000000)
                                                  / CLK_PERIOD_PS;

    localparam int unsigned CNT_W               = 32;
    localparam int unsigned GLITCH_W            = 8;

    // reset state
    typedef enum logic [1:0] {
        SWR_RUN,
        SWR_HOLD,
        SWR_TIMEOUT
    } swr_state_t;

    // reset causes gathered together
    typedef struct packed {
        logic supply_low;
        logic manual;
        logic watchdog;
    } swr_cause_t;

    localparam logic [CNT_W-1:0]    CNT_ZERO    = 32'h0000_0000;
    localparam logic [GLITCH_W-1:0] GLITCH_ZERO = 8'h00;
    localparam logic [GLITCH_W-1:0] KICK_FILT_CYC = 8'h01;

endpackage : swr_pkg

/* core/swr_sync.sv */
/*
 * swr_sync: two-flop synchroniser with a qualified output that follows the
 * synchronised level only after it has been stable for FILT_CYC cycles.
 * assumes core_clk and a synchronous active-low reset.
 */
module swr_sync
    import swr_pkg::*;
#(
    parameter logic             RST_VAL  = 1'b1,
    parameter logic [GLITCH_W-1:0] FILT_CYC = 8'h01
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic din,
    output logic      dout
);
    logic                meta_ff;
    logic                sync_ff;
    logic [GLITCH_W-1:0] stable_ff;
    logic                dout_ff;

    wire                 same      = (sync_ff == dout_ff);
    wire                 qualified = (stable_ff >= FILT_CYC - 8'h01);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_ff   <= RST_VAL;
            sync_ff   <= RST_VAL;
            stable_ff <= GLITCH_ZERO;
            dout_ff   <= RST_VAL;
        end else if (clk_en) begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            if (same) begin
                stable_ff <= GLITCH_ZERO;
            end else if (qualified) begin
                stable_ff <= GLITCH_ZERO;
                dout_ff   <= sync_ff;
            end else begin
                stable_ff <= stable_ff + 8'h01;
            end
        end
    end

    assign dout = dout_ff;

endmodule // swr_sync

/* core/swr_top.sv */
/*
 * swr_top: supervisory reset generator with supply, manual and watchdog causes.
 * assumes supply_low_in and kick_float_in come from analog logic as digital
 * levels synchronous to core_clk; manual and kick pins are asynchronous.
 * assumes rst_n is held low for at least one core_clk edge; reset takes effect whatever clk_en is.
 * clk_en low freezes every register, both synchronisers included, so the
 * timeout and watchdog periods stretch by the frozen cycles.
 * both reset outputs and the expiry flag come straight from flip-flops.
 */
// Behaviour
// - The active-low reset output falls on supply low, manual reset low or watchdog expiry.
// - The active-high reset output rises on those same three causes.
// - Both outputs stay asserted for the full timeout after every cause has cleared.
// - Manual reset lows under about 100 ns are rejected; the far side holds them 1 us or more.
// - A kick input steady for longer than the watchdog period expires the watchdog.
// - The watchdog count clears on reset, on manual reset and on each kick edge.
// - Kick pulses of 50 ns count as edges; the far side keeps them at least that wide.
// - A floating or three-stated kick input disables the watchdog.
// - The watchdog is held clear while reset is asserted and counts once it is released.
// - The timeout is at least 140 ms and also follows manual reset release.
module swr_top
    import swr_pkg::*;
#(
    parameter longint unsigned TIMEOUT_CYC = RST_TIMEOUT_CYC,
    parameter longint unsigned WD_CYC      = WD_PERIOD_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic supply_low_in,
    input  wire logic manual_reset_in_n,
    input  wire logic watchdog_kick_in,
    input  wire logic kick_float_in,
    output logic      reset_out_n,
    output logic      reset_out,
    output logic      watchdog_expired
);
    logic             mr_n_q;
    logic             kick_q;
    logic             kick_prev_ff;
    logic             nxt_kick_prev;
    swr_state_t       state_ff;
    swr_state_t       nxt_state;
    logic [CNT_W-1:0] tmo_cnt_ff;
    logic [CNT_W-1:0] nxt_tmo_cnt;
    logic [CNT_W-1:0] wd_cnt_ff;
    logic [CNT_W-1:0] nxt_wd_cnt;
    logic             rst_n_ff;
    logic             nxt_rst_n;
    logic             rst_ff;
    logic             nxt_rst;
    logic             wd_exp_ff;
    logic             nxt_wd_exp;
    swr_cause_t       cause;
    logic             kick_edge;
    logic             wd_enable;
    logic             in_reset;
    logic             wd_clr_rst;
    logic             wd_clr_mr;
    logic             wd_clr_kick;
    logic             wd_clr_off;
    logic             wd_clear;
    logic             wd_hit;
    logic             tmo_done;
    logic             tmo_run;
    logic             any_level;
    logic             any_cause;
    logic             nxt_in_reset;
    logic             nxt_asserted;

    // manual reset glitch filter, 100 ns
    swr_sync #(
        .RST_VAL  (1'b1),
        .FILT_CYC (GLITCH_W'(MR_GLITCH_CYC))
    ) u_mr_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .din      (manual_reset_in_n),
        .dout     (mr_n_q)
    );

    // kick synchroniser, a 50 ns pulse is still seen
    swr_sync #(
        .RST_VAL  (1'b0),
        .FILT_CYC (KICK_FILT_CYC)
    ) u_kick_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .din      (watchdog_kick_in),
        .dout     (kick_q)
    );

    // watchdog and timeout decode
    assign kick_edge    = (kick_q != kick_prev_ff);
    assign wd_enable    = !kick_float_in;
    assign in_reset     = (state_ff != SWR_RUN);
    assign wd_clr_rst   = in_reset;
    assign wd_clr_mr    = !mr_n_q;
    assign wd_clr_kick  = kick_edge;
    assign wd_clr_off   = !wd_enable;
    assign wd_clear     = wd_clr_rst || wd_clr_mr || wd_clr_kick || wd_clr_off;
    assign wd_hit       = wd_enable && (wd_cnt_ff >= CNT_W'(WD_CYC - 1));
    assign tmo_done     = (tmo_cnt_ff >= CNT_W'(TIMEOUT_CYC - 1));

    // reset causes
    assign cause.supply_low = supply_low_in;
    assign cause.manual     = !mr_n_q;
    assign cause.watchdog   = wd_hit && !in_reset;

    assign any_level    = cause.supply_low || cause.manual;
    assign any_cause    = any_level || cause.watchdog;

    // next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SWR_RUN: begin
                if (any_level) begin
                    nxt_state = SWR_HOLD;
                end else if (cause.watchdog) begin
                    nxt_state = SWR_TIMEOUT;
                end
            end
            SWR_HOLD: begin
                if (!any_level) begin
                    nxt_state = SWR_TIMEOUT;
                end
            end
            SWR_TIMEOUT: begin
                if (any_level) begin
                    nxt_state = SWR_HOLD;
                end else if (tmo_done) begin
                    nxt_state = SWR_RUN;
                end
            end
            default: nxt_state = SWR_HOLD;
        endcase
    end

    // next values
    assign nxt_in_reset  = (nxt_state != SWR_RUN);
    assign tmo_run       = (state_ff == SWR_TIMEOUT) && (nxt_state == SWR_TIMEOUT);
    assign nxt_tmo_cnt   = tmo_run ? (tmo_cnt_ff + 32'h0000_0001) : CNT_ZERO;
    assign nxt_wd_cnt    = wd_clear ? CNT_ZERO : (wd_cnt_ff + 32'h0000_0001);
    assign nxt_kick_prev = kick_q;

    // output next values, asserted in the same cycle as a new cause
    assign nxt_asserted  = nxt_in_reset || any_cause;
    assign nxt_rst_n     = !nxt_asserted;
    assign nxt_rst       = nxt_asserted;
    assign nxt_wd_exp    = cause.watchdog || (wd_exp_ff && nxt_in_reset);

    // reset state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= SWR_HOLD;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // timeout counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tmo_cnt_ff <= CNT_ZERO;
        end else if (clk_en) begin
            tmo_cnt_ff <= nxt_tmo_cnt;
        end
    end

    // watchdog counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wd_cnt_ff <= CNT_ZERO;
        end else if (clk_en) begin
            wd_cnt_ff <= nxt_wd_cnt;
        end
    end

    // kick level history
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            kick_prev_ff <= 1'b0;
        end else if (clk_en) begin
            kick_prev_ff <= nxt_kick_prev;
        end
    end

    // active-low output
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rst_n_ff <= 1'b0;
        end else if (clk_en) begin
            rst_n_ff <= nxt_rst_n;
        end
    end

    // active-high output
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rst_ff <= 1'b1;
        end else if (clk_en) begin
            rst_ff <= nxt_rst;
        end
    end

    // expiry flag, set wins over clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wd_exp_ff <= 1'b0;
        end else if (clk_en) begin
            wd_exp_ff <= nxt_wd_exp;
        end
    end

    // outputs straight from the flops
    assign reset_out_n      = rst_n_ff;
    assign reset_out        = rst_ff;
    assign watchdog_expired = wd_exp_ff;

endmodule // swr_top

/* verification/swr_cpu_model.sv */
/* swr_cpu_model: processor side, toggles the kick pin every gap+1 cycles.
   assumes gap of 13 or more, so each level lasts at least 50 ns. */
module swr_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       kick_en,
    input  wire logic       float_en,
    input  wire logic [7:0] gap,
    output logic            watchdog_kick_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_ff = 8'h00;
    logic       pin_ff = 1'b0;
    logic       flt_ff = 1'b0;
    always_ff @(posedge core_clk) begin
        flt_ff <= float_en;
        cnt_ff <= (kick_en && cnt_ff < gap) ? cnt_ff + 8'h01 : 8'h00;
        if (float_en != flt_ff) pin_ff <= ~pin_ff;
        else if (kick_en && !float_en && cnt_ff >= gap) pin_ff <= ~pin_ff;
    end
    assign watchdog_kick_in = pin_ff;
endmodule // swr_cpu_model

/* verification/swr_monitor.sv */
/* swr_monitor: port assertions for swr_top.
   assumes clk_en low only while reset is asserted, and short sim timeouts. */
module swr_monitor
    import swr_pkg::*;
#(
    parameter longint unsigned TIMEOUT_CYC = 50,
    parameter longint unsigned WD_CYC      = 200
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic supply_low_in,
    input wire logic manual_reset_in_n,
    input wire logic watchdog_kick_in,
    input wire logic kick_float_in,
    input wire logic reset_out_n,
    input wire logic reset_out,
    input wire logic watchdog_expired
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mlo_ff, calm_ff, quiet_ff;
    logic        k_ff;
    always_ff @(posedge core_clk) begin
        k_ff     <= watchdog_kick_in;
        mlo_ff   <= (!rst_n || manual_reset_in_n) ? '0 : mlo_ff + 1;
        calm_ff  <= (!rst_n || supply_low_in || !manual_reset_in_n) ? '0 : calm_ff + 1;
        quiet_ff <= (!rst_n || !reset_out_n || kick_float_in || k_ff != watchdog_kick_in)
                    ? '0 : quiet_ff + 1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_inv; reset_out != reset_out_n; endproperty
    a_inv: assert property (p_inv) else $error("outputs not complementary");
    property p_sup; supply_low_in |=> !reset_out_n; endproperty
    a_sup: assert property (p_sup) else $error("supply low missed");
    property p_hold; $fell(supply_low_in) |-> !reset_out_n [*8]; endproperty
    a_hold: assert property (p_hold) else $error("early release");
    property p_mr; mlo_ff >= 32 |-> !reset_out_n; endproperty
    a_mr: assert property (p_mr) else $error("manual low missed");
    property p_gl; $rose(manual_reset_in_n) && mlo_ff < 20 && reset_out_n && !supply_low_in
        |=> reset_out_n [*8]; endproperty
    a_gl: assert property (p_gl) else $error("glitch not rejected");
    property p_wdc; $rose(watchdog_expired) |-> quiet_ff + 4 >= WD_CYC; endproperty
    a_wdc: assert property (p_wdc) else $error("early expiry");
    property p_wdq; quiet_ff <= WD_CYC + 4; endproperty
    a_wdq: assert property (p_wdq) else $error("watchdog missed");
    property p_rel; $rose(reset_out_n) |-> calm_ff + 1 >= TIMEOUT_CYC; endproperty
    a_rel: assert property (p_rel) else $error("timeout short");
    property p_frz; !clk_en |=> $stable(reset_out_n) && $stable(watchdog_expired); endproperty
    a_frz: assert property (p_frz) else $error("outputs moved while frozen");
endmodule // swr_monitor
bind swr_top swr_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC), .WD_CYC(WD_CYC)) u_mon (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .supply_low_in(supply_low_in),
    .manual_reset_in_n(manual_reset_in_n), .watchdog_kick_in(watchdog_kick_in),
    .kick_float_in(kick_float_in), .reset_out_n(reset_out_n), .reset_out(reset_out),
    .watchdog_expired(watchdog_expired));

/* verification/swr_test.sv */
/* swr_test: self-checking bench for swr_top.
   assumes cpu model and monitor are compiled first. */
module swr_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TO = 50;
    localparam int WD = 200;
    logic core_clk = 1'b0, rst_n = 1'b0, supply_low_in = 1'b0, manual_reset_in_n = 1'b1;
    logic kick_en = 1'b1, kick_float_in = 1'b0, kick, reset_out_n, reset_out, watchdog_expired;
    logic       clk_en = 1'b1;
    logic [7:0] gap = 8'h0d;
    int num_errors = 0, checked = 0, cyc = 0, n;
    swr_cpu_model cpu (.core_clk(core_clk), .kick_en(kick_en), .float_en(kick_float_in),
        .gap(gap), .watchdog_kick_in(kick));
    swr_top #(.TIMEOUT_CYC(TO), .WD_CYC(WD)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(clk_en), .supply_low_in(supply_low_in), .manual_reset_in_n(manual_reset_in_n),
        .watchdog_kick_in(kick), .kick_float_in(kick_float_in), .reset_out_n(reset_out_n),
        .reset_out(reset_out), .watchdog_expired(watchdog_expired));
    initial forever #2 core_clk = ~core_clk;
    task end_sim;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            $display("Error %0t: timeout", $time);
            end_sim();
        end
    end
    task tick; @(posedge core_clk); #1; endtask
    task chk(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin num_errors++; $display("Error %0t: got %b want %b", $time, got, exp); end
    endtask
    task wait_lvl(input logic lvl, input int lim);
        n = 0;
        while (reset_out_n !== lvl && n < lim) begin tick(); n++; end
    endtask
    task rel(input int lo);
        wait_lvl(1'b1, lo + 40);
        chk(n >= lo && n <= lo + 12, 1'b1);
        chk(reset_out, 1'b0);
    endtask
    task stay(input int k);
        repeat (k) begin tick(); chk(reset_out_n, 1'b1); end
    endtask
    initial begin
        n = $urandom(32'h1d65);
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rel(TO);
        $display("power-on done");
        @(posedge core_clk) supply_low_in <= 1'b1;
        tick(); tick(); chk(reset_out_n, 1'b0);
        chk(reset_out, 1'b1);
        repeat ($urandom_range(20, 3)) tick();
        @(posedge core_clk) supply_low_in <= 1'b0;
        repeat (10) tick();
        @(posedge core_clk) clk_en <= 1'b0;
        repeat ($urandom_range(40, 20)) begin
            tick();
            chk(reset_out_n, 1'b0);
        end
        @(posedge core_clk) clk_en <= 1'b1;
        rel(TO - 10);
        $display("supply done");
        @(posedge core_clk) manual_reset_in_n <= 1'b0;
        repeat (32) tick();
        chk(reset_out_n, 1'b0);
        repeat (230) tick();
        @(posedge core_clk) manual_reset_in_n <= 1'b1;
        rel(TO + 26);
        $display("manual done");
        repeat (3) begin
            gap <= 8'($urandom_range(40, 13));
            @(posedge core_clk) manual_reset_in_n <= 1'b0;
            repeat ($urandom_range(20, 2)) tick();
            @(posedge core_clk) manual_reset_in_n <= 1'b1;
            stay(40);
        end
        stay(500);
        $display("glitch and kick done");
        @(posedge core_clk) kick_en <= 1'b0;
        wait_lvl(1'b0, WD + 20);
        chk(n >= WD - 45 && n <= WD + 8, 1'b1);
        tick(); chk(watchdog_expired, 1'b1);
        kick_en <= 1'b1;
        rel(TO - 2);
        chk(watchdog_expired, 1'b0);
        $display("watchdog done");
        @(posedge core_clk) kick_en <= 1'b0;
        kick_float_in <= 1'b1;
        stay(3 * WD);
        $display("float done");
        end_sim();
    end
endmodule // swr_test
